// ===== verilog/fu_pkg.sv
/*
  package of the flag unit: register offsets, field layout, reset values,
  instruction classes and machine-cycle counts.
  assumes: included first in compile order; used only by package:: name.
*/
package fu_pkg;

  // ----------------------------------------------------------------
  // register offsets (byte addresses, one word each)
  // ----------------------------------------------------------------
  localparam logic [7:0] OFS_FLAGS   = 8'h00;
  localparam logic [7:0] OFS_ACC     = 8'h04;
  localparam logic [7:0] OFS_OPERAND = 8'h08;
  localparam logic [7:0] OFS_RESULT  = 8'h0C;
  localparam logic [7:0] OFS_COMMAND = 8'h10;
  localparam logic [7:0] OFS_STATUS  = 8'h14;

  // ----------------------------------------------------------------
  // flag_register bit positions
  // ----------------------------------------------------------------
  localparam int FLAG_H = 5;
  localparam int FLAG_I = 4;
  localparam int FLAG_N = 3;
  localparam int FLAG_Z = 2;
  localparam int FLAG_V = 1;
  localparam int FLAG_C = 0;

  // status field positions
  localparam int ST_BUSY    = 0;
  localparam int ST_WAITING = 1;
  localparam int ST_NMI     = 2;
  localparam int ST_LEFT    = 8;
  localparam int ST_LAST    = 16;

  // ----------------------------------------------------------------
  // reset values
  // ----------------------------------------------------------------
  localparam logic [5:0]  RST_FLAGS = 6'h10;
  localparam logic [7:0]  RST_ACC   = 8'h00;
  localparam logic [15:0] RST_WORD  = 16'h0000;
  localparam logic [1:0]  ACC_PAD   = 2'b11;

  // ----------------------------------------------------------------
  // implied flag opcodes
  // ----------------------------------------------------------------
  localparam logic [7:0] OP_CLEAR_CARRY = 8'h0C;
  localparam logic [7:0] OP_CLEAR_IRQ   = 8'h0E;
  localparam logic [7:0] OP_CLEAR_OVF   = 8'h0A;
  localparam logic [7:0] OP_SET_CARRY   = 8'h0D;
  localparam logic [7:0] OP_SET_IRQ     = 8'h0F;
  localparam logic [7:0] OP_SET_OVF     = 8'h0B;
  localparam logic [7:0] OP_ACC_TO_FLAG = 8'h06;
  localparam logic [7:0] OP_FLAG_TO_ACC = 8'h07;

  // ----------------------------------------------------------------
  // instruction classes and addressing modes
  // ----------------------------------------------------------------
  typedef enum logic [3:0] {
    CL_FLAG  = 4'h0, CL_ALU  = 4'h1, CL_RMW   = 4'h2, CL_STORE = 4'h3,
    CL_BRAN  = 4'h4, CL_TRAP = 4'h5, CL_RTI   = 4'h6, CL_WAIT  = 4'h7,
    CL_DAA   = 4'h8, CL_CPX  = 4'h9, CL_LD16  = 4'hA, CL_TEST  = 4'hB
  } fu_class_t;

  typedef enum logic [1:0] {
    AM_IMM = 2'b00, AM_DIR = 2'b01, AM_EXT = 2'b10, AM_IDX = 2'b11
  } fu_amode_t;

  // command word carried from the bus to the decoders
  typedef struct packed {
    logic [1:0] sub;
    fu_amode_t  amode;
    fu_class_t  cls;
    logic [7:0] opcode;
  } fu_cmd_t;

  // ----------------------------------------------------------------
  // machine-cycle counts
  // ----------------------------------------------------------------
  localparam logic [3:0] CYC_FLAG   = 4'h2;
  localparam logic [3:0] CYC_ALU_IM = 4'h2;
  localparam logic [3:0] CYC_RMW_A  = 4'h2;
  localparam logic [3:0] CYC_RMW_X  = 4'h6;
  localparam logic [3:0] CYC_RMW_I  = 4'h7;
  localparam logic [3:0] CYC_STA_D  = 4'h4;
  localparam logic [3:0] CYC_W16_IM = 4'h3;
  localparam logic [3:0] CYC_BRANCH = 4'h4;
  localparam logic [3:0] CYC_TRAP   = 4'hC;
  localparam logic [3:0] CYC_RTI    = 4'hA;
  localparam logic [3:0] CYC_WAIT   = 4'h9;
  localparam logic [3:0] CYC_IRQ    = 4'hC;
  localparam logic [3:0] CYC_WAKE   = 4'h4;

endpackage

// ===== verilog/fu_cycles.sv
/*
  machine-cycle count of one instruction from its class and mode.
  assumes: purely combinational; the caller loads the count into its counter.
*/
module fu_cycles (
  // command
  input  wire fu_pkg::fu_cmd_t cmd_i,
  // count
  output logic [3:0]           cycles_o
);

  // ----------------------------------------------------------------
  // decode
  // ----------------------------------------------------------------
  always_comb begin
    cycles_o = fu_pkg::CYC_FLAG;
    case (cmd_i.cls)
      fu_pkg::CL_FLAG, fu_pkg::CL_DAA, fu_pkg::CL_TEST: cycles_o = fu_pkg::CYC_FLAG;
      fu_pkg::CL_ALU: cycles_o = fu_pkg::CYC_ALU_IM + 4'(cmd_i.amode);
      fu_pkg::CL_RMW: begin
        if (cmd_i.amode == fu_pkg::AM_IDX) cycles_o = fu_pkg::CYC_RMW_I;
        else if (cmd_i.amode == fu_pkg::AM_IMM) cycles_o = fu_pkg::CYC_RMW_A;
        else cycles_o = fu_pkg::CYC_RMW_X;
      end
      fu_pkg::CL_STORE: begin
        // direct is the shortest store; immediate is treated as direct
        cycles_o = fu_pkg::CYC_STA_D + 4'(cmd_i.amode) - ((cmd_i.amode == fu_pkg::AM_IMM)
                   ? 4'h0 : 4'h1);
        if (cmd_i.sub != 2'b00) cycles_o = cycles_o + 4'h1;
      end
      fu_pkg::CL_CPX, fu_pkg::CL_LD16: cycles_o = fu_pkg::CYC_W16_IM + 4'(cmd_i.amode);
      fu_pkg::CL_BRAN: cycles_o = fu_pkg::CYC_BRANCH;
      fu_pkg::CL_TRAP: cycles_o = fu_pkg::CYC_TRAP;
      fu_pkg::CL_RTI:  cycles_o = fu_pkg::CYC_RTI;
      fu_pkg::CL_WAIT: cycles_o = fu_pkg::CYC_WAIT;
      default: cycles_o = fu_pkg::CYC_FLAG;
    endcase
  end

endmodule

// ===== verilog/fu_flags.sv
/*
  next flags, accumulator and result word for one instruction.
  assumes: purely combinational; values are committed by the caller at the
  end of the instruction's last machine cycle.
*/
module fu_flags (
  // command and present state
  input  wire fu_pkg::fu_cmd_t cmd_i,
  input  wire logic [5:0]      flags_i,
  input  wire logic [7:0]      acc_i,
  input  wire logic [15:0]     oper_i,
  input  wire logic [15:0]     res_i,
  // next state
  output logic [5:0]           flags_o,
  output logic [7:0]           acc_o,
  output logic [15:0]          res_o
);

  logic [7:0]  sh;
  logic        sc;
  logic [15:0] diff;

  // ----------------------------------------------------------------
  // flag logic
  // ----------------------------------------------------------------
  always_comb begin
    flags_o = flags_i;
    acc_o   = acc_i;
    res_o   = res_i;
    // arithmetic shift right keeps the sign, left shift feeds a zero
    sc      = cmd_i.sub[0] ? oper_i[0] : oper_i[7];
    sh      = cmd_i.sub[0] ? {oper_i[7], oper_i[7:1]} : {oper_i[6:0], 1'b0};
    diff    = res_i - oper_i;
    case (cmd_i.cls)
      fu_pkg::CL_FLAG: begin
        case (cmd_i.opcode)
          fu_pkg::OP_CLEAR_CARRY: flags_o[fu_pkg::FLAG_C] = 1'b0;
          fu_pkg::OP_CLEAR_IRQ:   flags_o[fu_pkg::FLAG_I] = 1'b0;
          fu_pkg::OP_CLEAR_OVF:   flags_o[fu_pkg::FLAG_V] = 1'b0;
          fu_pkg::OP_SET_CARRY:   flags_o[fu_pkg::FLAG_C] = 1'b1;
          fu_pkg::OP_SET_IRQ:     flags_o[fu_pkg::FLAG_I] = 1'b1;
          fu_pkg::OP_SET_OVF:     flags_o[fu_pkg::FLAG_V] = 1'b1;
          fu_pkg::OP_ACC_TO_FLAG: flags_o = acc_i[5:0];
          fu_pkg::OP_FLAG_TO_ACC: acc_o = {fu_pkg::ACC_PAD, flags_i};
          default: flags_o = flags_i;
        endcase
      end
      fu_pkg::CL_TEST: begin
        case (cmd_i.sub)
          2'b00: flags_o[fu_pkg::FLAG_V] = (res_i[7:0] == 8'h80);
          2'b01: flags_o[fu_pkg::FLAG_C] = (res_i[7:0] == 8'h00);
          2'b10: flags_o[fu_pkg::FLAG_V] = (oper_i[7:0] == 8'h80);
          default: flags_o[fu_pkg::FLAG_V] = (oper_i[7:0] == 8'h7F);
        endcase
      end
      fu_pkg::CL_RMW: begin
        res_o = {8'h00, sh};
        flags_o[fu_pkg::FLAG_N] = sh[7];
        flags_o[fu_pkg::FLAG_Z] = (sh == 8'h00);
        flags_o[fu_pkg::FLAG_C] = sc;
        flags_o[fu_pkg::FLAG_V] = sh[7] ^ sc;
      end
      fu_pkg::CL_DAA: begin
        // a carry already set is never cleared here
        if (acc_i[7:4] > 4'h9) flags_o[fu_pkg::FLAG_C] = 1'b1;
      end
      fu_pkg::CL_CPX: begin
        flags_o[fu_pkg::FLAG_N] = diff[15];
        flags_o[fu_pkg::FLAG_Z] = (diff == 16'h0000);
        flags_o[fu_pkg::FLAG_V] = (res_i[15] ^ oper_i[15]) & (res_i[15] ^ diff[15]);
      end
      fu_pkg::CL_LD16: begin
        res_o = oper_i;
        flags_o[fu_pkg::FLAG_N] = oper_i[15];
        flags_o[fu_pkg::FLAG_Z] = (oper_i == 16'h0000);
        flags_o[fu_pkg::FLAG_V] = 1'b0;
      end
      fu_pkg::CL_STORE: begin
        if (cmd_i.sub != 2'b00) begin
          flags_o[fu_pkg::FLAG_N] = res_i[15];
          flags_o[fu_pkg::FLAG_Z] = (res_i == 16'h0000);
          flags_o[fu_pkg::FLAG_V] = 1'b0;
        end
      end
      fu_pkg::CL_RTI:  flags_o = oper_i[5:0];
      fu_pkg::CL_TRAP: flags_o[fu_pkg::FLAG_I] = 1'b1;
      default: flags_o = flags_i;
    endcase
  end

endmodule

// ===== verilog/fu_top.sv
/*
  flag unit of an 8-bit processor core: flag_register, accumulator A,
  instruction timing in machine cycles and interrupt entry, reached over APB.
  assumes: one clock, one machine cycle per clock; irq_n_i and nmi_n_i come
  from pins outside the clock domain; APB master follows the usual protocol.
*/
// Behaviour
// - flag register: bit5 half-carry, 4 irq mask, 3 negative, 2 zero, 1 overflow, 0 carry.
// - implied opcodes clear carry, irq mask (0E) or overflow (0A) only.
// - implied opcodes set carry (0D), irq mask or overflow (0B) only.
// - flag clear, set and transfer take one byte and two cycles.
// - opcode 06 loads every flag from the matching accumulator A bit.
// - opcode 07 copies flags into accumulator A, flags untouched.
// - a tested flag is set when its test holds, cleared otherwise.
// - result test: overflow set exactly when the result is 10000000.
// - result test: carry set exactly when the result is 00000000.
// - decimal adjust sets carry when upper digit exceeds nine, never clears it.
// - operand-minimum test sets overflow when the operand was 10000000.
// - operand-maximum test sets overflow when the operand was 01111111.
// - shifts make overflow equal negative XOR carry after the shift.
// - 16-bit index compare takes negative from the difference's top sign bit.
// - 16-bit compare sets overflow on two's complement overflow of the whole 16-bit difference.
// - 16-bit loads and stores set negative from result bit 15.
// - return from interrupt restores all six flags from the stacked value.
// - taking an interrupt sets mask; masked wait ends only on non-maskable interrupt.
// - accumulator ALU takes 2, 3, 4, 5 cycles immediate, direct, extended, indexed.
// - shifts take 2 on accumulator, 6 extended, 7 indexed.
// - every relative branch takes 4 cycles, taken or not.
// - software trap 12, return from interrupt 10, wait 9 cycles.
// - interrupt entry takes 12 cycles, or 4 when already waiting.
module fu_top #(
  parameter int CNT_W = 4
) (
  // clock and reset
  input  wire logic        clk_i,
  input  wire logic        nrst_i,
  // apb slave
  input  wire logic        psel_i,
  input  wire logic        penable_i,
  input  wire logic        pwrite_i,
  input  wire logic [7:0]  paddr_i,
  input  wire logic [31:0] pwdata_i,
  output logic             pready_o,
  output logic [31:0]      prdata_o,
  output logic             pslverr_o,
  // interrupt pins
  input  wire logic        irq_n_i,
  input  wire logic        nmi_n_i,
  // state
  output logic [5:0]       flags_o,
  output logic             busy_o,
  output logic             waiting_o
);

  // ----------------------------------------------------------------
  // elaboration check
  // ----------------------------------------------------------------
  if (CNT_W < 4) begin : g_bad_width
    $error("CNT_W must hold the longest count of 12");
  end

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    FS_IDLE = 2'b00,
    FS_EXEC = 2'b01,
    FS_WAIT = 2'b10,
    FS_INTR = 2'b11
  } fu_fsm_t;

  typedef struct packed {
    fu_fsm_t         st;
    logic [CNT_W-1:0] cnt;
    logic [3:0]      last;
    logic [5:0]      flags;
    logic [7:0]      acc;
    logic [15:0]     oper;
    logic [15:0]     res;
    fu_pkg::fu_cmd_t cmd;
    logic [5:0]      pflags;
    logic [7:0]      pacc;
    logic [15:0]     pres;
    logic            busy;
    logic            waiting;
    logic            ready;
    logic            err;
    logic [31:0]     rdata;
    logic [2:0]      irq_s;
    logic [2:0]      nmi_s;
    logic            irq_f;
    logic            nmi_f;
    logic            nmi_pend;
  } fu_state_t;

  fu_state_t s_reg;
  fu_state_t s_next;

  fu_pkg::fu_cmd_t new_cmd;
  logic [3:0]      new_cycles;
  logic [5:0]      calc_flags;
  logic [7:0]      calc_acc;
  logic [15:0]     calc_res;

  assign new_cmd = fu_pkg::fu_cmd_t'(pwdata_i[15:0]);

  // ----------------------------------------------------------------
  // decoders
  // ----------------------------------------------------------------
  fu_cycles u_cycles (
    .cmd_i    (new_cmd),
    .cycles_o (new_cycles)
  );

  fu_flags u_flags (
    .cmd_i   (new_cmd),
    .flags_i (s_reg.flags),
    .acc_i   (s_reg.acc),
    .oper_i  (s_reg.oper),
    .res_i   (s_reg.res),
    .flags_o (calc_flags),
    .acc_o   (calc_acc),
    .res_o   (calc_res)
  );

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  logic access;
  logic commit;
  logic mapped;
  logic nmi_edge;
  logic irq_want;
  logic take_irq;
  logic issue;

  always_comb begin
    s_next   = s_reg;
    access   = psel_i & penable_i;
    commit   = access & s_reg.ready & pwrite_i & ~s_reg.err;
    mapped   = 1'b1;
    issue    = 1'b0;
    s_next.ready = 1'b0;
    s_next.err   = 1'b0;

    // pin synchronisers: a change counts once the last two stages agree
    s_next.irq_s = {s_reg.irq_s[1:0], irq_n_i};
    s_next.nmi_s = {s_reg.nmi_s[1:0], nmi_n_i};
    if (s_reg.irq_s[1] == s_reg.irq_s[2]) s_next.irq_f = s_reg.irq_s[2];
    if (s_reg.nmi_s[1] == s_reg.nmi_s[2]) s_next.nmi_f = s_reg.nmi_s[2];
    // non-maskable request is a falling edge, kept until taken
    nmi_edge = s_reg.nmi_f & ~s_next.nmi_f;
    irq_want = ~s_reg.irq_f & ~s_reg.flags[fu_pkg::FLAG_I];
    take_irq = s_reg.nmi_pend | irq_want;

    // apb: one wait state, answer prepared in the first access cycle
    if (access & ~s_reg.ready) begin
      s_next.ready = 1'b1;
      s_next.rdata = 32'h0000_0000;
      if (paddr_i == fu_pkg::OFS_FLAGS) begin
        s_next.rdata = {26'h000_0000, s_reg.flags};
      end else if (paddr_i == fu_pkg::OFS_ACC) begin
        s_next.rdata = {24'h00_0000, s_reg.acc};
      end else if (paddr_i == fu_pkg::OFS_OPERAND) begin
        s_next.rdata = {16'h0000, s_reg.oper};
      end else if (paddr_i == fu_pkg::OFS_RESULT) begin
        s_next.rdata = {16'h0000, s_reg.res};
      end else if (paddr_i == fu_pkg::OFS_COMMAND) begin
        s_next.rdata = {16'h0000, s_reg.cmd};
      end else if (paddr_i == fu_pkg::OFS_STATUS) begin
        s_next.rdata[fu_pkg::ST_BUSY]    = s_reg.busy;
        s_next.rdata[fu_pkg::ST_WAITING] = s_reg.waiting;
        s_next.rdata[fu_pkg::ST_NMI]     = s_reg.nmi_pend;
        s_next.rdata[fu_pkg::ST_LEFT +: 4] = 4'(s_reg.cnt);
        s_next.rdata[fu_pkg::ST_LAST +: 4] = s_reg.last;
      end else begin
        mapped = 1'b0;
      end
      // no register changes under a running instruction; status is read-only
      s_next.err = ~mapped | (pwrite_i & (s_reg.busy | (paddr_i == fu_pkg::OFS_STATUS)));
    end

    // register writes take effect on the edge that sees pready high
    if (commit) begin
      if (paddr_i == fu_pkg::OFS_FLAGS) begin
        s_next.flags = pwdata_i[5:0];
      end else if (paddr_i == fu_pkg::OFS_ACC) begin
        s_next.acc = pwdata_i[7:0];
      end else if (paddr_i == fu_pkg::OFS_OPERAND) begin
        s_next.oper = pwdata_i[15:0];
      end else if (paddr_i == fu_pkg::OFS_RESULT) begin
        s_next.res = pwdata_i[15:0];
      end else if (paddr_i == fu_pkg::OFS_COMMAND) begin
        issue = 1'b1;
      end
    end

    // instruction sequencing
    case (s_reg.st)
      FS_IDLE: begin
        if (issue) begin
          s_next.cmd    = new_cmd;
          s_next.pflags = calc_flags;
          s_next.pacc   = calc_acc;
          s_next.pres   = calc_res;
          s_next.cnt    = CNT_W'(new_cycles);
          s_next.last   = new_cycles;
          s_next.st     = FS_EXEC;
        end else if (take_irq) begin
          s_next.cnt  = CNT_W'(fu_pkg::CYC_IRQ);
          s_next.last = fu_pkg::CYC_IRQ;
          s_next.st   = FS_INTR;
        end
      end
      FS_EXEC: begin
        s_next.cnt = s_reg.cnt - CNT_W'(1);
        if (s_reg.cnt == CNT_W'(1)) begin
          // results land at the end of the last machine cycle
          s_next.flags = s_reg.pflags;
          s_next.acc   = s_reg.pacc;
          s_next.res   = s_reg.pres;
          s_next.st    = (s_reg.cmd.cls == fu_pkg::CL_WAIT) ? FS_WAIT : FS_IDLE;
        end
      end
      FS_WAIT: begin
        // with the mask set only the non-maskable request wakes the core
        if (take_irq) begin
          s_next.cnt  = CNT_W'(fu_pkg::CYC_WAKE);
          s_next.last = fu_pkg::CYC_WAKE;
          s_next.st   = FS_INTR;
        end
      end
      default: begin
        s_next.cnt = s_reg.cnt - CNT_W'(1);
        if (s_reg.cnt == CNT_W'(1)) begin
          s_next.flags[fu_pkg::FLAG_I] = 1'b1;
          s_next.st = FS_IDLE;
        end
      end
    endcase

    // pending edge clears when its entry starts; a new edge wins
    if (((s_reg.st == FS_IDLE) & ~issue) | (s_reg.st == FS_WAIT)) begin
      if (s_reg.nmi_pend) s_next.nmi_pend = 1'b0;
    end
    if (nmi_edge) s_next.nmi_pend = 1'b1;

    s_next.busy    = (s_next.st != FS_IDLE);
    s_next.waiting = (s_next.st == FS_WAIT);
  end

  // ----------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      s_reg          <= '0;
      s_reg.st       <= FS_IDLE;
      s_reg.flags    <= fu_pkg::RST_FLAGS;
      s_reg.acc      <= fu_pkg::RST_ACC;
      s_reg.oper     <= fu_pkg::RST_WORD;
      s_reg.res      <= fu_pkg::RST_WORD;
      s_reg.pflags   <= fu_pkg::RST_FLAGS;
      s_reg.irq_s    <= 3'b111;
      s_reg.nmi_s    <= 3'b111;
      s_reg.irq_f    <= 1'b1;
      s_reg.nmi_f    <= 1'b1;
    end else begin
      s_reg <= s_next;
    end
  end

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  assign pready_o  = s_reg.ready;
  assign prdata_o  = s_reg.rdata;
  assign pslverr_o = s_reg.err;
  assign flags_o   = s_reg.flags;
  assign busy_o    = s_reg.busy;
  assign waiting_o = s_reg.waiting;

endmodule

// ===== test/fu_chk.sv
/*
  checker of the flag unit: timing and flag relations at the top ports.
  assumes: bound to fu_top; one clock, reset active low.
*/
module fu_chk (
  // clock and reset
  input wire logic        clk_i,
  input wire logic        nrst_i,
  // apb
  input wire logic        psel_i,
  input wire logic        penable_i,
  input wire logic        pwrite_i,
  input wire logic [7:0]  paddr_i,
  input wire logic        pready_o,
  input wire logic [31:0] prdata_o,
  input wire logic        pslverr_o,
  // state
  input wire logic [5:0]  flags_o,
  input wire logic        busy_o,
  input wire logic        waiting_o
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge clk_i); endclocking
  default disable iff (!nrst_i);
  // ----------------------------------------------------------------
  // busy run counter, cleared in the wait state
  // ----------------------------------------------------------------
  logic [4:0] run_reg;
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) run_reg <= 5'h00;
    else if (busy_o && !waiting_o) run_reg <= run_reg + 5'h01;
    else run_reg <= 5'h00;
  end
  property p_ready_wait; psel_i && penable_i && !pready_o |=> pready_o; endproperty
  a_ready_wait: assert property (p_ready_wait) else $error("ready late");
  property p_ready_pulse; pready_o |=> !pready_o; endproperty
  a_ready_pulse: assert property (p_ready_pulse) else $error("ready held");
  property p_busy_min; $rose(busy_o) |=> busy_o; endproperty
  a_busy_min: assert property (p_busy_min) else $error("instruction too short");
  property p_busy_bound; run_reg <= 5'h0c; endproperty
  a_busy_bound: assert property (p_busy_bound) else $error("busy too long");
  property p_flag_hold; busy_o ##1 busy_o |-> $stable(flags_o); endproperty
  a_flag_hold: assert property (p_flag_hold) else $error("flags moved early");
  property p_wake; waiting_o ##1 !waiting_o |-> ##[0:4] (!busy_o && flags_o[4]); endproperty
  a_wake: assert property (p_wake) else $error("slow wake");
  property p_wait_busy; waiting_o |-> busy_o; endproperty
  a_wait_busy: assert property (p_wait_busy) else $error("wait not busy");
  property p_cmd_busy;
    psel_i && penable_i && pwrite_i && pready_o && !pslverr_o
      && paddr_i == fu_pkg::OFS_COMMAND |=> busy_o;
  endproperty
  a_cmd_busy: assert property (p_cmd_busy) else $error("command not started");
  property p_flag_rd;
    pready_o && psel_i && !pwrite_i && paddr_i == fu_pkg::OFS_FLAGS
      |-> prdata_o[31:6] == 26'h000_0000;
  endproperty
  a_flag_rd: assert property (p_flag_rd) else $error("flag read wide");
  c_wait: cover property (waiting_o ##1 !waiting_o);
  c_err: cover property (pready_o && pslverr_o);
  c_long: cover property (run_reg == 5'h0c);
endmodule
bind fu_top fu_chk u_chk (.clk_i(clk_i), .nrst_i(nrst_i), .psel_i(psel_i),
  .penable_i(penable_i), .pwrite_i(pwrite_i), .paddr_i(paddr_i), .pready_o(pready_o),
  .prdata_o(prdata_o), .pslverr_o(pslverr_o), .flags_o(flags_o), .busy_o(busy_o),
  .waiting_o(waiting_o));

// ===== test/fu_irq_src.sv
/*
  peripheral interrupt source driving the request pins.
  assumes: requests come from the bench; pins idle high.
*/
module fu_irq_src (
  // clock and reset
  input  wire logic clk_i,
  input  wire logic nrst_i,
  // requests
  input  wire logic irq_req_i,
  input  wire logic nmi_req_i,
  // pins
  output logic      irq_n_o,
  output logic      nmi_n_o
);
  timeunit 1ns;
  timeprecision 1ps;
  // level held until the bench sees the request serviced, like a real peripheral
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      irq_n_o <= 1'b1;
      nmi_n_o <= 1'b1;
    end else begin
      irq_n_o <= !irq_req_i;
      nmi_n_o <= !nmi_req_i;
    end
  end
endmodule

// ===== test/test_flag_ops_and_cycle_timing.sv
/*
  testbench of the flag unit: apb master, flag model, cycle table.
  assumes: fu_top with one wait state apb; fu_irq_src on the pins.
*/
module test_flag_ops_and_cycle_timing;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk_i = 1'b0, nrst_i = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic irq_req = 1'b0, nmi_req = 1'b0, irq_n, nmi_n, pready, pslverr, busy, waiting;
  logic [7:0]  paddr = 8'h00;
  logic [31:0] pwdata = 32'h0000_0000, prdata, rd;
  logic [5:0]  flags, f;
  logic [7:0]  a, ops [8] = '{8'h0C, 8'h0E, 8'h0A, 8'h0D, 8'h0F, 8'h0B, 8'h06, 8'h07};
  logic [19:0] ctab [$] = '{20'h2_0100, 20'h3_1100, 20'h4_2100, 20'h5_3100, 20'h2_0200,
    20'h6_2200, 20'h7_3200, 20'h4_1300, 20'h5_2300, 20'h6_3300, 20'h5_5300, 20'h6_6300,
    20'h7_7300, 20'h4_0400, 20'hC_0500, 20'hA_0600};
  logic err;
  int fail_count = 0, comparisons = 0, n;
  initial forever #5 clk_i = !clk_i;
  fu_irq_src u_fu_irq_src (.clk_i(clk_i), .nrst_i(nrst_i), .irq_req_i(irq_req),
    .nmi_req_i(nmi_req), .irq_n_o(irq_n), .nmi_n_o(nmi_n));
  fu_top u_fu_top (.clk_i(clk_i), .nrst_i(nrst_i), .psel_i(psel), .penable_i(penable),
    .pwrite_i(pwrite), .paddr_i(paddr), .pwdata_i(pwdata), .pready_o(pready),
    .prdata_o(prdata), .pslverr_o(pslverr), .irq_n_i(irq_n), .nmi_n_i(nmi_n),
    .flags_o(flags), .busy_o(busy), .waiting_o(waiting));
  // ----------------------------------------------------------------
  // tasks
  // ----------------------------------------------------------------
  task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      fail_count++;
      $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic end_of_test();
    $display("comparisons %0d mismatches %0d", comparisons, fail_count);
    if (fail_count == 0 && comparisons > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  task automatic apb(input logic w, input logic [7:0] ad, input logic [31:0] d);
    @(posedge clk_i);
    psel <= 1'b1; penable <= 1'b0; pwrite <= w; paddr <= ad; pwdata <= d;
    @(posedge clk_i);
    penable <= 1'b1;
    do @(posedge clk_i); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0; penable <= 1'b0;
  endtask
  // counts edges until busy falls or the wait state is entered
  task automatic count_busy();
    n = 0;
    do begin
      @(posedge clk_i);
      #1 n++;
    end while (busy === 1'b1 && waiting !== 1'b1 && n < 40);
  endtask
  task automatic exec(input logic [15:0] c);
    apb(1'b1, fu_pkg::OFS_COMMAND, {16'h0000, c});
    count_busy();
  endtask
  initial begin
    #300us;
    fail_count++;
    end_of_test();
  end
  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial begin
    void'($urandom(32'h0433cb2d));
    repeat (12) @(posedge clk_i);
    nrst_i <= 1'b1;
    apb(1'b0, fu_pkg::OFS_FLAGS, 32'h0);
    check("reset flags", rd, {26'h0, fu_pkg::RST_FLAGS});
    apb(1'b0, 8'h18, 32'h0);
    check("unmapped", err, 1'b1);
    foreach (ops[i]) begin
      f = 6'($urandom());
      a = 8'($urandom());
      apb(1'b1, fu_pkg::OFS_FLAGS, {26'h0, f | 6'h10});
      apb(1'b1, fu_pkg::OFS_ACC, {24'h0, a});
      f = f | 6'h10;
      exec({8'h00, ops[i]});
      check("flag op cycles", n, 2);
      case (ops[i])
        8'h0C: f[0] = 1'b0;
        8'h0E: f[4] = 1'b0;
        8'h0A: f[1] = 1'b0;
        8'h0D: f[0] = 1'b1;
        8'h0F: f[4] = 1'b1;
        8'h0B: f[1] = 1'b1;
        8'h06: f = a[5:0];
        default: a = {2'b11, f};
      endcase
      check("flag op flags", flags, f);
      apb(1'b0, fu_pkg::OFS_ACC, 32'h0);
      check("flag op acc", rd, {24'h0, a});
    end
    for (int s = 0; s < 8; s++) begin
      a = (s[2:1] == 2'd1) ? 8'h00 : (s[2:1] == 2'd3) ? 8'h7F : 8'h80;
      a = a ^ {7'h00, s[0]};
      apb(1'b1, fu_pkg::OFS_RESULT, {24'h0, a});
      apb(1'b1, fu_pkg::OFS_OPERAND, {24'h0, a});
      exec({s[2:1], 14'h0B00});
      check("test flag", flags[(s[2:1] == 2'd1) ? 0 : 1], !s[0]);
    end
    for (int s = 0; s < 2; s++) begin
      apb(1'b1, fu_pkg::OFS_OPERAND, s ? 32'hC0 : 32'h40);
      exec(16'h0200);
      check("shift nvc", {flags[3], flags[1], flags[0]}, s ? 3'b101 : 3'b110);
    end
    for (int s = 0; s < 2; s++) begin
      apb(1'b1, fu_pkg::OFS_FLAGS, s ? 32'h10 : 32'h11);
      apb(1'b1, fu_pkg::OFS_ACC, s ? 32'hA0 : 32'h00);
      exec(16'h0800);
      check("adjust carry", flags[0], 1'b1);
    end
    // 0 - (-32768) and (-32768) - 1 both overflow; the first also turns negative
    for (int s = 0; s < 2; s++) begin
      apb(1'b1, fu_pkg::OFS_RESULT, s ? 32'h0000_0000 : 32'h0000_8000);
      apb(1'b1, fu_pkg::OFS_OPERAND, s ? 32'h0000_8000 : 32'h0000_0001);
      exec(16'h0900);
      check("compare nv", {flags[3], flags[1]}, s ? 2'b11 : 2'b01);
    end
    exec(16'h0A00);
    check("load16 n", flags[3], 1'b1);
    foreach (ctab[i]) begin
      exec(ctab[i][15:0]);
      check("cycles", n, ctab[i][19:16]);
    end
    f = 6'($urandom());
    apb(1'b1, fu_pkg::OFS_OPERAND, {26'h0, f});
    exec(16'h0600);
    check("return flags", flags, f);
    apb(1'b1, fu_pkg::OFS_FLAGS, 32'h00);
    irq_req <= 1'b1;
    // look just after each edge so the entry's first busy edge is not lost
    for (int k = 0; k < 20 && busy !== 1'b1; k++) begin
      @(posedge clk_i);
      #1;
    end
    count_busy();
    irq_req <= 1'b0;
    check("entry cycles", n, 12);
    check("entry mask", flags[4], 1'b1);
    exec(16'h0700);
    check("wait cycles", n, 9);
    irq_req <= 1'b1;
    repeat (20) @(posedge clk_i);
    check("masked wait holds", waiting, 1'b1);
    nmi_req <= 1'b1;
    repeat (6) @(posedge clk_i);
    nmi_req <= 1'b0;
    for (int k = 0; k < 20 && busy === 1'b1; k++) @(posedge clk_i);
    #1 check("nmi wake", {busy, waiting, flags[4]}, 3'b001);
    irq_req <= 1'b0;
    end_of_test();
  end
endmodule
